// File: verilog/bas_pkg.sv
package bas_pkg;

  // Register numbers that the wide forms refuse, and the test alias destination
  localparam logic [3:0] REG_SP      = 4'hd;
  localparam logic [3:0] REG_PC      = 4'hf;
  localparam logic [3:0] REG_ALLONES = 4'hf;

  // Word alignment of the program counter
  localparam logic [31:0] PC_ALIGN_MASK = 32'hffff_fffc;

  // Shift type codes of the type field, and the full-word shift amount
  localparam logic [1:0] SH_LSL = 2'h0;
  localparam logic [1:0] SH_LSR = 2'h1;
  localparam logic [1:0] SH_ASR = 2'h2;
  localparam logic [1:0] SH_ROR = 2'h3;
  localparam logic [5:0] SH_FULL = 6'h20;

  // Narrow encodings: mask and match on the one halfword
  localparam logic [15:0] ADRN_MASK  = 16'hf800;
  localparam logic [15:0] ADRN_MATCH = 16'ha000;
  localparam logic [15:0] ANDN_MASK  = 16'hffc0;
  localparam logic [15:0] ANDN_MATCH = 16'h4000;
  localparam logic [15:0] ASRN_MASK  = 16'hf800;
  localparam logic [15:0] ASRN_MATCH = 16'h1000;

  // Wide encodings: mask and match on the first halfword
  localparam logic [15:0] ADRW_MASK  = 16'hfbff;
  localparam logic [15:0] ADRS_MATCH = 16'hf2af;
  localparam logic [15:0] ADRA_MATCH = 16'hf20f;
  localparam logic [15:0] ANDI_MASK  = 16'hfbe0;
  localparam logic [15:0] ANDI_MATCH = 16'hf000;
  localparam logic [15:0] ANDR_MASK  = 16'hffe0;
  localparam logic [15:0] ANDR_MATCH = 16'hea00;
  localparam logic [15:0] ASRW_MASK  = 16'hffef;
  localparam logic [15:0] ASRW_MATCH = 16'hea4f;

  // Field positions (least significant bit of each field)
  localparam int F_S    = 4;
  localparam int F_I    = 10;
  localparam int F_RN   = 0;
  localparam int F_B15  = 15;
  localparam int F_CONST_MID_BITS = 12;
  localparam int F_RDW  = 8;
  localparam int F_SHIFT_LOW_BITS = 6;
  localparam int F_TYPE = 4;
  localparam int F_RMW  = 0;
  localparam int F_RDA  = 8;
  localparam int F_SHIFT_AMOUNT_FIELD = 6;
  localparam int F_RMN  = 3;
  localparam int F_RDN  = 0;

  // Flag reset values
  localparam logic FLAG_RST = 1'b0;

  // Operation classes after decode
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADR,
    OP_ANDI,
    OP_ANDR,
    OP_ASRI
  } bas_op_t;

endpackage : bas_pkg

// File: verilog/bas_imm_expand.sv
`timescale 1ns/1ps
module bas_imm_expand
  import bas_pkg::*;
(
  // Packed i, mid bits and low byte
  input  wire logic [11:0] immPacked,
  input  wire logic        carryIn,
  // Expanded constant
  output logic      [31:0] constVal,
  output logic             carryOut
);

  logic [7:0]  lowByte;
  logic [31:0] unrot;
  logic [4:0]  rot;
  logic [31:0] rotated;
  logic        isRep;

  assign lowByte = immPacked[7:0];
  assign isRep   = (immPacked[11:10] == 2'h0);
  assign unrot   = {24'h00_0000, 1'b1, immPacked[6:0]};
  assign rot     = immPacked[11:7];
  // Rotation is never zero here: the top bits are nonzero
  assign rotated = (unrot >> rot) | (unrot << (6'h20 - {1'b0, rot}));

  // Replicated patterns keep the incoming carry
  always_comb begin
    constVal = rotated;
    carryOut = rotated[31];
    if (isRep) begin
      carryOut = carryIn;
      case (immPacked[9:8])
        2'h0:    constVal = {24'h00_0000, lowByte};
        2'h1:    constVal = {8'h00, lowByte, 8'h00, lowByte};
        2'h2:    constVal = {lowByte, 8'h00, lowByte, 8'h00};
        default: constVal = {lowByte, lowByte, lowByte, lowByte};
      endcase
    end
  end

endmodule : bas_imm_expand

// File: verilog/bas_shifter.sv
`timescale 1ns/1ps
module bas_shifter
  import bas_pkg::*;
(
  // Operand and shift selection
  input  wire logic [31:0] srcVal,
  input  wire logic [1:0]  shType,
  input  wire logic        shRrx,
  input  wire logic [5:0]  shAmt,
  input  wire logic        carryIn,
  // Shifted result
  output logic      [31:0] outVal,
  output logic             carryOut
);

  logic [32:0] lslW;
  logic [32:0] lsrW;
  logic [32:0] asrW;
  logic [31:0] rorV;

  // Extra bit below or above holds the last bit shifted out
  assign lslW = {1'b0, srcVal} << shAmt;
  assign lsrW = {srcVal, 1'b0} >> shAmt;
  assign asrW = 33'($signed({srcVal, 1'b0}) >>> shAmt);
  assign rorV = (srcVal >> shAmt[4:0]) | (srcVal << (6'h20 - {1'b0, shAmt[4:0]}));

  // Amount zero passes the value and keeps the carry
  always_comb begin
    outVal   = srcVal;
    carryOut = carryIn;
    if (shRrx) begin
      outVal   = {carryIn, srcVal[31:1]};
      carryOut = srcVal[0];
    end else if (shAmt != 6'h00) begin
      case (shType)
        SH_LSL: begin
          outVal   = lslW[31:0];
          carryOut = lslW[32];
        end
        SH_LSR: begin
          outVal   = lsrW[32:1];
          carryOut = lsrW[0];
        end
        SH_ASR: begin
          outVal   = asrW[32:1];
          carryOut = asrW[0];
        end
        default: begin
          outVal   = rorV;
          carryOut = rorV[31];
        end
      endcase
    end
  end

endmodule : bas_shifter

// File: verilog/bas_exec.sv
// Overview of operation
// - Address form aligns PC down to 4, adds or subtracts immediate, writes result.
// - Wide immediate AND with destination all ones and S set is the flag test.
// - Immediate AND updates flags when S is 1; constant expanded with carry.
// - Immediate AND with destination or first register 13 or 15, except destination 15 of the flag test, is unpredictable.
// - Immediate AND writes conjunction; N, Z from result, C from expansion, V kept.
// - Narrow register AND: one register both roles, no shift, flags outside group.
// - Wide register AND with destination all ones and S set is the flag test.
// - Wide register AND decodes shift from type and mid:low bits; flags follow S.
// - Wide register AND using register 13 or 15 in any field, except destination 15 of the flag test, is unpredictable.
// - Register AND shifts second operand with carry in, writes the conjunction.
// - Register AND flags: N bit 31, Z zero, C shifter carry, V kept.
// - Arithmetic right shift moves value down, filling with the sign bit.
// - Narrow arithmetic shift takes amount field; flags only outside a group.
// - Wide arithmetic shift updates flags when S is 1.
// - Wide arithmetic shift decodes amount with type 10; 13 or 15 unpredictable.
// - Immediate arithmetic shift covers amounts 1 through 32.
// - Arithmetic shift flags: N bit 31, Z zero, C carry-out, V kept.
`timescale 1ns/1ps
module bas_exec
  import bas_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Instruction in
  input  wire logic        instrValid,
  input  wire logic [31:0] instrWord,
  input  wire logic        instrWide,
  input  wire logic        inPredGroup,
  // Operand values
  input  wire logic [31:0] pcValue,
  input  wire logic [31:0] firstOpVal,
  input  wire logic [31:0] secondOpVal,
  // Direct load of program_status_flags
  input  wire logic        flagsLoad,
  input  wire logic [3:0]  flagsIn,
  // Execution result
  output logic             execDone_r,
  output logic             regWrite_r,
  output logic      [3:0]  destReg_r,
  output logic      [31:0] result_r,
  output logic             testAlias_r,
  output logic             unpredictable_r,
  output logic             undecoded_r,
  // program_status_flags
  output logic             flagN_r,
  output logic             flagZ_r,
  output logic             flagC_r,
  output logic             flagV_r
);

  // Shift decode for an encoded type and five-bit amount
  function automatic logic [8:0] decodeShift(input logic [1:0] typ,
                                             input logic [4:0] amt);
    logic [5:0] n;
    logic       rrx;
    n   = {1'b0, amt};
    rrx = 1'b0;
    // Right shifts read an amount of zero as a full word
    if ((typ == SH_LSR || typ == SH_ASR) && amt == 5'h00) begin
      n = SH_FULL;
    // Rotate by zero would do nothing, so it means extend by one
    end else if (typ == SH_ROR && amt == 5'h00) begin
      rrx = 1'b1;
      n   = 6'h01;
    end
    return {typ, rrx, n};
  endfunction : decodeShift

  // Stack pointer or program counter check
  function automatic logic isSpPc(input logic [3:0] r);
    return (r == REG_SP) || (r == REG_PC);
  endfunction : isSpPc

  // Halfwords
  logic [15:0] hwN;
  logic [15:0] hw1;
  logic [15:0] hw2;
  assign hwN = instrWord[15:0];
  assign hw1 = instrWord[31:16];
  assign hw2 = instrWord[15:0];

  // Encoding matches
  logic isAdrN;
  logic isAdrS;
  logic isAdrA;
  logic isAndI;
  logic isAndN;
  logic isAndR;
  logic isAsrN;
  logic isAsrW;
  logic hw2Clear;
  // Wide immediate forms need bit 15 of the second halfword clear
  assign hw2Clear = !hw2[F_B15];
  assign isAdrN = !instrWide && ((hwN & ADRN_MASK) == ADRN_MATCH);
  assign isAndN = !instrWide && ((hwN & ANDN_MASK) == ANDN_MATCH);
  assign isAsrN = !instrWide && ((hwN & ASRN_MASK) == ASRN_MATCH);
  assign isAdrS = instrWide && hw2Clear && ((hw1 & ADRW_MASK) == ADRS_MATCH);
  assign isAdrA = instrWide && hw2Clear && ((hw1 & ADRW_MASK) == ADRA_MATCH);
  assign isAndI = instrWide && hw2Clear && ((hw1 & ANDI_MASK) == ANDI_MATCH);
  assign isAndR = instrWide && ((hw1 & ANDR_MASK) == ANDR_MATCH);
  assign isAsrW = instrWide && hw2Clear && ((hw1 & ASRW_MASK) == ASRW_MATCH)
                  && (hw2[F_TYPE +: 2] == SH_ASR);

  // Wide fields
  logic       sBit;
  logic [3:0] rnW;
  logic [3:0] rdW;
  logic [3:0] rmW;
  logic [4:0] amtW;
  logic [1:0] typW;
  assign sBit = hw1[F_S];
  assign rnW  = hw1[F_RN +: 4];
  assign rdW  = hw2[F_RDW +: 4];
  assign rmW  = hw2[F_RMW +: 4];
  assign amtW = {hw2[F_CONST_MID_BITS +: 3], hw2[F_SHIFT_LOW_BITS +: 2]};
  assign typW = hw2[F_TYPE +: 2];

  // Narrow fields
  logic [3:0] rdN;
  logic [3:0] rmN;
  logic [3:0] rdA;
  logic [4:0] amtN;
  assign rdN  = {1'b0, hwN[F_RDN +: 3]};
  assign rmN  = {1'b0, hwN[F_RMN +: 3]};
  assign rdA  = {1'b0, hwN[F_RDA +: 3]};
  assign amtN = hwN[F_SHIFT_AMOUNT_FIELD +: 5];

  // Test alias when destination is all ones with S set
  logic aliasI;
  logic aliasR;
  assign aliasI = isAndI && rdW == REG_ALLONES && sBit;
  assign aliasR = isAndR && rdW == REG_ALLONES && sBit;

  // Operation class
  // Priority is harmless: no two handled encodings overlap
  bas_op_t opKind;
  assign opKind = (isAdrN || isAdrS || isAdrA) ? OP_ADR :
                  isAndI                       ? OP_ANDI :
                  (isAndN || isAndR)           ? OP_ANDR :
                  (isAsrN || isAsrW)           ? OP_ASRI : OP_NONE;

  // Shift selection: narrow AND takes LSL 0, the others decode
  logic [8:0] shDec;
  assign shDec = isAndN ? {SH_LSL, 1'b0, 6'h00} :
                 isAsrN ? decodeShift(SH_ASR, amtN) :
                 isAsrW ? decodeShift(SH_ASR, amtW) :
                          decodeShift(typW, amtW);

  // Shifter on the second operand, carry in from the flag
  // Carry in is the flag held at the taking edge, so back to back works
  logic [31:0] shOut;
  logic        shCarry;
  bas_shifter uShift (
    .srcVal   (secondOpVal),
    .shType   (shDec[8:7]),
    .shRrx    (shDec[6]),
    .shAmt    (shDec[5:0]),
    .carryIn  (flagC_r),
    .outVal   (shOut),
    .carryOut (shCarry)
  );

  // Twelve-bit immediate shared by the expander and the wide address forms
  logic [11:0] imm12;
  assign imm12 = {hw1[F_I], hw2[F_CONST_MID_BITS +: 3], hw2[7:0]};

  // Modified constant expansion with the current carry
  logic [31:0] immConst;
  logic        immCarry;
  bas_imm_expand uExpand (
    .immPacked (imm12),
    .carryIn   (flagC_r),
    .constVal  (immConst),
    .carryOut  (immCarry)
  );

  // Address form: aligned PC plus or minus the offset
  logic [31:0] adrImm;
  logic [31:0] pcAligned;
  logic [31:0] adrSum;
  logic        adrWide;
  assign adrWide = isAdrS || isAdrA;
  assign adrImm = isAdrN ? {22'h00_0000, hwN[7:0], 2'h0}
                         : {20'h0_0000, imm12};
  assign pcAligned = pcValue & PC_ALIGN_MASK;
  assign adrSum = isAdrS ? pcAligned - adrImm : pcAligned + adrImm;

  // Candidate results of the two conjunction classes
  logic [31:0] andImmRes;
  logic [31:0] andRegRes;
  assign andImmRes = firstOpVal & immConst;
  assign andRegRes = firstOpVal & shOut;

  // Result, carry and destination per class
  logic [31:0] resVal;
  logic        resCarry;
  logic [3:0]  destReg;
  logic        setFlags;
  logic        unpred;
  assign resVal = (opKind == OP_ADR)  ? adrSum :
                  (opKind == OP_ANDI) ? andImmRes :
                  (opKind == OP_ANDR) ? andRegRes :
                                        shOut;
  assign resCarry = (opKind == OP_ANDI) ? immCarry : shCarry;
  assign destReg = isAdrN            ? rdA :
                   (isAndN || isAsrN) ? rdN :
                                        rdW;

  // Flag update enable; the group only gates the narrow forms
  logic setNarrow;
  logic setWide;
  assign setNarrow = (isAndN || isAsrN) && !inPredGroup;
  assign setWide   = (isAndI || isAndR || isAsrW) && sBit;
  assign setFlags  = setNarrow || setWide;

  // Register 13 or 15 in each wide field
  logic rdBad;
  logic rnBad;
  logic rmBad;
  assign rdBad = isSpPc(rdW);
  assign rnBad = isSpPc(rnW);
  assign rmBad = isSpPc(rmW);

  // Unpredictable register choices; alias skips the destination
  // Narrow forms reach only r0 to r7, so they never qualify
  logic unpAndI;
  logic unpAndR;
  logic unpAsr;
  logic unpAdr;
  assign unpAndI = isAndI && ((!aliasI && rdBad) || rnBad);
  assign unpAndR = isAndR && ((!aliasR && rdBad) || rnBad || rmBad);
  assign unpAsr  = isAsrW && (rdBad || rmBad);
  assign unpAdr  = adrWide && rdBad;
  assign unpred  = unpAndI || unpAndR || unpAsr || unpAdr;

  // Next values of the result stage
  logic        known;
  logic        alias_nxt;
  logic        doFlags;
  assign known     = instrValid && (opKind != OP_NONE);
  assign alias_nxt = aliasI || aliasR;
  assign doFlags   = known && setFlags;

  // Status pulses, each qualified by a presented instruction
  logic regWrite_nxt;
  logic testAlias_nxt;
  logic unpred_nxt;
  logic undec_nxt;
  assign regWrite_nxt  = known && !alias_nxt;
  assign testAlias_nxt = instrValid && alias_nxt;
  assign unpred_nxt    = instrValid && unpred;
  assign undec_nxt     = instrValid && (opKind == OP_NONE);

  // Result stage, a single pulse per accepted instruction
  // Destination and result move every cycle; read them with the done pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      execDone_r      <= 1'b0;
      regWrite_r      <= 1'b0;
      destReg_r       <= 4'h0;
      result_r        <= 32'h0000_0000;
      testAlias_r     <= 1'b0;
      unpredictable_r <= 1'b0;
      undecoded_r     <= 1'b0;
    end else begin
      execDone_r      <= instrValid;
      regWrite_r      <= regWrite_nxt;
      destReg_r       <= destReg;
      result_r        <= resVal;
      testAlias_r     <= testAlias_nxt;
      unpredictable_r <= unpred_nxt;
      undecoded_r     <= undec_nxt;
    end
  end

  // Next flags: a direct load beats an instruction update; V is only loaded
  logic flagN_nxt;
  logic flagZ_nxt;
  logic flagC_nxt;
  logic flagV_nxt;
  assign flagN_nxt = flagsLoad ? flagsIn[3] :
                     doFlags   ? resVal[31] :
                                 flagN_r;
  assign flagZ_nxt = flagsLoad ? flagsIn[2] :
                     doFlags   ? (resVal == 32'h0000_0000) :
                                 flagZ_r;
  assign flagC_nxt = flagsLoad ? flagsIn[1] :
                     doFlags   ? resCarry :
                                 flagC_r;
  assign flagV_nxt = flagsLoad ? flagsIn[0] : flagV_r;

  // Flag registers
  always_ff @(posedge clock) begin
    if (rst) begin
      flagN_r <= FLAG_RST;
      flagZ_r <= FLAG_RST;
      flagC_r <= FLAG_RST;
      flagV_r <= FLAG_RST;
    end else begin
      flagN_r <= flagN_nxt;
      flagZ_r <= flagZ_nxt;
      flagC_r <= flagC_nxt;
      flagV_r <= flagV_nxt;
    end
  end

endmodule : bas_exec

// File: tb/bas_exec_asserts.sv
`timescale 1ns/1ps
module bas_exec_chk
  import bas_pkg::*;
(
  // Inputs of the block
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        instrValid,
  input wire logic [31:0] instrWord,
  input wire logic        instrWide,
  input wire logic        inPredGroup,
  input wire logic [31:0] pcValue,
  input wire logic [31:0] firstOpVal,
  input wire logic [31:0] secondOpVal,
  input wire logic        flagsLoad,
  // Outputs watched
  input wire logic        regWrite_r,
  input wire logic [31:0] result_r,
  input wire logic        testAlias_r,
  input wire logic        unpredictable_r,
  input wire logic        flagN_r,
  input wire logic        flagZ_r,
  input wire logic        flagC_r,
  input wire logic        flagV_r
);
  // Decode of the word taken at this edge
  logic [15:0] lo;
  logic [15:0] hi;
  logic        adrN, andN, asrN, andI, andR;
  logic [3:0]  nzcv;
  assign lo   = instrWord[15:0];
  assign hi   = instrWord[31:16];
  assign adrN = instrValid && !instrWide && ((lo & ADRN_MASK) == ADRN_MATCH);
  assign andN = instrValid && !instrWide && ((lo & ANDN_MASK) == ANDN_MATCH);
  assign asrN = instrValid && !instrWide && ((lo & ASRN_MASK) == ASRN_MATCH);
  assign andI = instrValid && instrWide && ((hi & ANDI_MASK) == ANDI_MATCH) && !lo[15];
  assign andR = instrValid && instrWide && ((hi & ANDR_MASK) == ANDR_MATCH);
  assign nzcv = {flagN_r, flagZ_r, flagC_r, flagV_r};

  // Expected values held one cycle, since results are registered
  logic [31:0] adrExp_r, andExp_r;
  logic        sign_r;
  always_ff @(posedge clock) begin
    adrExp_r <= (pcValue & PC_ALIGN_MASK) + {22'h0, lo[7:0], 2'b00};
    andExp_r <= firstOpVal & secondOpVal;
    sign_r   <= secondOpVal[31];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // A load in the same cycle would win over the instruction
  sequence s_andn_free;
    andN && !inPredGroup && !flagsLoad;
  endsequence
  sequence s_andn_group;
    andN && inPredGroup && !flagsLoad;
  endsequence

  property p_adr_narrow;
    adrN |=> regWrite_r && (result_r == adrExp_r);
  endproperty
  a_adr_narrow: assert property (p_adr_narrow)
    else $error("narrow address result wrong");
  property p_andi_alias;
    andI && hi[4] && (lo[11:8] == REG_ALLONES) |=> testAlias_r && !regWrite_r;
  endproperty
  a_andi_alias: assert property (p_andi_alias)
    else $error("immediate test alias missed");
  property p_andn_res;
    andN |=> regWrite_r && (result_r == andExp_r);
  endproperty
  a_andn_res: assert property (p_andn_res)
    else $error("narrow conjunction result wrong");
  property p_andn_group;
    s_andn_group |=> $stable(nzcv);
  endproperty
  a_andn_group: assert property (p_andn_group)
    else $error("flags changed inside group");
  property p_andn_flags;
    s_andn_free |=> flagN_r == andExp_r[31] && flagZ_r == (andExp_r == 32'h0) && $stable(flagC_r);
  endproperty
  a_andn_flags: assert property (p_andn_flags)
    else $error("narrow conjunction flags wrong");
  property p_andr_unp;
    andR && (lo[3:0] == REG_SP || lo[3:0] == REG_PC) |=> unpredictable_r;
  endproperty
  a_andr_unp: assert property (p_andr_unp)
    else $error("second operand 13 or 15 not flagged");
  property p_asr_full;
    asrN && (lo[10:6] == 5'h0) |=> result_r == {32{sign_r}};
  endproperty
  a_asr_full: assert property (p_asr_full)
    else $error("full shift not all sign bits");
  property p_v_keep;
    !flagsLoad |=> $stable(flagV_r);
  endproperty
  a_v_keep: assert property (p_v_keep)
    else $error("overflow flag changed");
endmodule : bas_exec_chk

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  // Status codes {write, alias, unpredictable, undecoded} and operands
  localparam logic [3:0]  WR = 4'h8;
  localparam logic [3:0]  AL = 4'h4;
  localparam logic [3:0]  UP = 4'h2;
  localparam logic [3:0]  UD = 4'h1;
  localparam logic [31:0] OPA = 32'h8234_56f8;
  localparam logic [31:0] OPB = 32'h9000_00b1;

  // Drive and observe
  logic        clock, rst, instrValid, instrWide, inPredGroup, flagsLoad;
  logic [31:0] instrWord, pcValue, firstOpVal, secondOpVal, result;
  logic [3:0]  flagsIn, destReg, fl;
  logic        execDone, regWrite, testAlias, unpred, undec, fN, fZ, fC, fV;
  logic [8:0]  stat;
  logic [32:0] x;
  logic [4:0]  amt;
  int          n_fail = 0, checks_done = 0, cyc = 0, n;
  assign stat = {execDone, regWrite, testAlias, unpred, undec, fN, fZ, fC, fV};

  // Block under test
  bas_exec uut (
    .clock(clock), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
    .instrWide(instrWide), .inPredGroup(inPredGroup), .pcValue(pcValue),
    .firstOpVal(firstOpVal), .secondOpVal(secondOpVal), .flagsLoad(flagsLoad),
    .flagsIn(flagsIn), .execDone_r(execDone), .regWrite_r(regWrite), .destReg_r(destReg),
    .result_r(result), .testAlias_r(testAlias), .unpredictable_r(unpred),
    .undecoded_r(undec), .flagN_r(fN), .flagZ_r(fZ), .flagC_r(fC), .flagV_r(fV)
  );

  // Clock at 100 MHz
  always #5 clock = ~clock;

  // Hang guard, far above the roughly 72 cycles used
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      end_of_test();
    end
  end

  // Reference shifter returning {carry, value}
  function automatic logic [32:0] shf(input logic [31:0] v, input logic [1:0] t,
                                      input int s, input logic c);
    logic [32:0] r;
    r = {c, v};
    case (t)
      2'h0: if (s > 0) r = {1'b0, v} << s;
      2'h1: r = {v, 1'b0} >> s;
      2'h2: r = $signed({v, 1'b0}) >>> s;
      default: r = (s > 0) ? {v[s-1], (v >> s) | (v << (32 - s))} : {v[0], c, v[31:1]};
    endcase
    if (t == 2'h1 || t == 2'h2) r = {r[0], r[32:1]};
    return r;
  endfunction : shf

  task automatic chk_res(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: value %h, expected %h", $time, g, e);
    end
  endtask : chk_res

  task automatic chk_bits(input logic [8:0] g, input logic [8:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: status %b, expected %b", $time, g, e);
    end
  endtask : chk_bits

  // One instruction: present at an edge, taken at the next, look after it
  task automatic run(input logic [31:0] w, input logic wd, pg, input logic [31:0] a, b);
    @(posedge clock);
    instrWord   <= w;
    instrWide   <= wd;
    inPredGroup <= pg;
    firstOpVal  <= a;
    secondOpVal <= b;
    instrValid  <= 1'b1;
    @(posedge clock);
    instrValid <= 1'b0;
    #1;
  endtask : run

  // Compare outputs, updating the flag model when flags are set
  task automatic chkx(input logic [3:0] d, input logic [31:0] r, input logic [3:0] st,
                      input logic sf, input logic cn);
    if (sf) fl = {r[31], r == 32'h0, cn, fl[0]};
    chk_bits(stat, {1'b1, st, fl});
    if (!st[0]) chk_res(result, r);
    if (st[3]) chk_res({28'h0, destReg}, {28'h0, d});
  endtask : chkx

  task automatic ldf(input logic [3:0] v);
    @(posedge clock);
    flagsLoad <= 1'b1;
    flagsIn   <= v;
    @(posedge clock);
    flagsLoad <= 1'b0;
    #1;
    fl = v;
    chk_bits(stat, {5'h0, v});
  endtask : ldf

  task end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    clock = 0; rst = 1; instrValid = 0; instrWord = 0; instrWide = 0; inPredGroup = 0;
    pcValue = 32'h0000_1237; firstOpVal = 0; secondOpVal = 0; flagsLoad = 0; flagsIn = 0;
    fl = 4'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk_bits(stat, 9'h0);
    $display("test reset done");
    ldf(4'h3);
    run(32'ha3ff, 0, 0, OPA, OPB); chkx(3, 32'h1630, WR, 0, 0);
    run({16'hf2af, 16'h7512}, 1, 0, OPA, OPB); chkx(5, 32'h0b22, WR, 0, 0);
    run({16'hf60f, 16'h0107}, 1, 0, OPA, OPB); chkx(1, 32'h1a3b, WR, 0, 0);
    run({16'hf20f, 16'h0d00}, 1, 0, OPA, OPB); chkx(13, 32'h1234, WR | UP, 0, 0);
    $display("test address done");
    ldf(4'h0);
    run({16'hf011, 16'h4255}, 1, 0, OPA, OPB); chkx(2, 32'h8000_0000, WR, 1, 1);
    run({16'hf011, 16'h02f0}, 1, 0, OPA, OPB); chkx(2, 32'hf0, WR, 1, fl[1]);
    run({16'hf011, 16'h0f0f}, 1, 0, OPA, OPB); chkx(0, 32'h8, AL, 1, fl[1]);
    run({16'hf00d, 16'h03ff}, 1, 0, OPA, OPB); chkx(3, 32'hf8, WR | UP, 0, 0);
    $display("test immediate conjunction done");
    run(32'h4008, 0, 1, OPA, OPB); chkx(0, OPA & OPB, WR, 0, 0);
    run(32'h4008, 0, 0, OPA, OPB); chkx(0, OPA & OPB, WR, 1, fl[1]);
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 8; k += 7) begin
        amt = k[4:0];
        n = ((t == 1 || t == 2) && k == 0) ? 32 : k;
        x = shf(OPB, t[1:0], n, fl[1]);
        run({16'hea11, 1'b0, amt[4:2], 4'h2, amt[1:0], t[1:0], 4'h3}, 1, 0, 32'hffff_ffff, OPB);
        chkx(2, x[31:0], WR, 1, x[32]);
      end
    end
    run({16'hea11, 16'h0f03}, 1, 0, OPA, OPB); chkx(0, OPA & OPB, AL, 1, fl[1]);
    run({16'hea01, 16'h020f}, 1, 0, OPA, OPB); chkx(2, OPA & OPB, WR | UP, 0, 0);
    $display("test register conjunction done");
    for (int k = 0; k < 6; k++) begin
      amt = (k % 3 == 0) ? 5'd1 : ((k % 3 == 1) ? 5'd31 : 5'd0);
      n = (amt == 5'd0) ? 32 : amt;
      x = shf(k < 3 ? OPB : 32'h4000_0003, 2'h2, n, fl[1]);
      run({16'h0, 5'b00010, amt, 6'h15}, 0, 0, OPA, k < 3 ? OPB : 32'h4000_0003);
      chkx(5, x[31:0], WR, 1, x[32]);
    end
    run(32'h1115, 0, 1, OPA, OPB); chkx(5, 32'hf900_000b, WR, 0, 0);
    x = shf(OPB, 2'h2, 1, fl[1]);
    run({16'hea4f, 16'h0466}, 1, 0, OPA, OPB); chkx(4, x[31:0], WR, 0, 0);
    x = shf(OPB, 2'h2, 32, fl[1]);
    run({16'hea5f, 16'h0426}, 1, 0, OPA, OPB); chkx(4, x[31:0], WR, 1, x[32]);
    x = shf(OPB, 2'h2, 1, fl[1]);
    run({16'hea4f, 16'h0d66}, 1, 0, OPA, OPB); chkx(13, x[31:0], WR | UP, 0, 0);
    run(32'hbf00, 0, 0, OPA, OPB); chkx(0, 32'h0, UD, 0, 0);
    $display("test shift done");
    end_of_test();
  end
endmodule : tb

bind bas_exec bas_exec_chk chk (
  .clock(clock), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
  .instrWide(instrWide), .inPredGroup(inPredGroup), .pcValue(pcValue),
  .firstOpVal(firstOpVal), .secondOpVal(secondOpVal), .flagsLoad(flagsLoad),
  .regWrite_r(regWrite_r), .result_r(result_r), .testAlias_r(testAlias_r),
  .unpredictable_r(unpredictable_r), .flagN_r(flagN_r), .flagZ_r(flagZ_r),
  .flagC_r(flagC_r), .flagV_r(flagV_r)
);
